// ---- tcs_capture.sv ----
// Purpose: probe sampling, trigger, storage qualifier and circular store
// Assumes: probes and target clock are asynchronous to MCLK_I
// Notes: registers on APB, zero wait state, memory read through APB
`timescale 1ns/1ps
module tcs_capture
   import tcs_pkg::*;
#(
   parameter int PW = 32, // probe channels
   parameter int DEPTH = 256, // acquisition memory words
   parameter int AW = 8 // memory address width
)
(
   input wire logic MCLK_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [PW-1:0] PROBE_I,
   input wire logic EXT_CLK_I,
   input wire logic XEVT_I,
   output logic TRIG_OUT_O
);

   // refuse shapes the pointer logic cannot serve
   generate
      if (PW < 1 || PW > 32 || DEPTH != (1 << AW) || AW < 1 || AW > 16)
      begin : g_chk
         $error("tcs_capture: bad PW, DEPTH or AW");
      end
   endgenerate

   localparam int EW = PW + 33; // entry: trig flag, stamp, sample
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   // masked compare, used by trigger and qualifier
   function automatic logic masked_eq(input logic [PW-1:0] v,
                                      input logic [PW-1:0] ref_v,
                                      input logic [PW-1:0] msk);
      masked_eq = (((v ^ ref_v) & msk) == '0);
   endfunction

   // software registers
   logic [CTRL_BITS-1:0] ctrl_q;
   logic [15:0] div_q;
   logic [PW-1:0] match_q, mmask_q, rlo_q, rhi_q, qval_q, qmask_q;
   logic [31:0] clim_q;
   logic [AW:0] pre_q;
   logic [AW-1:0] ridx_q;

   // acquisition state
   tcs_state_e st_q;
   logic [15:0] divc_q; // internal sample clock divider
   logic [31:0] stamp_q; // time base since start
   logic [31:0] scnt_q; // captured sample counter
   logic trig_q; // trigger seen on the capture side
   logic ovf_q; // buffer was full when a qualified sample came
   logic [AW-1:0] wptr_q; // next memory slot
   logic [AW:0] fill_q; // stored words, saturates at depth
   logic [AW:0] post_q; // post-trigger words written
   logic mtrig_q; // trigger word reached memory
   logic [AW-1:0] tidx_q; // slot holding the trigger word
   logic [PW-1:0] mem_smp_q [DEPTH];
   logic [31:0] mem_ts_q [DEPTH];

   // synchronisers: first stage read by second stage only
   logic [PW-1:0] prb_s1, prb_s2;
   logic ext_s1, ext_s2, ext_s3;
   logic evt_s1, evt_s2;

   // sample path
   logic smp_vld_q; // one-cycle sample pulse
   logic [PW-1:0] smp_q;
   logic [31:0] smp_ts_q;

   logic apb_wr, apb_rd, start_p, abort_p, running;
   logic int_tick, ext_tick, tick;
   logic hit, qual, drain, store_w, trig_w, fin;
   logic [AW:0] term;
   logic [EW-1:0] pop_w;

   tcs_fifo_if #(.W(EW)) fif ();

   tcs_buf2 #(.W(EW)) u_buf
   (
      .clk_i(MCLK_I),
      .rst_i(SRST_I),
      .bus(fif.store)
   );

   assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
   assign apb_rd = PSEL_I & ~PWRITE_I;
   assign start_p = apb_wr && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_START];
   assign abort_p = apb_wr && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_ABORT];
   assign running = (st_q == ST_RUN);

   // input synchronisers for probes, target clock and event line
   always_ff @(posedge MCLK_I)
   begin
      prb_s1 <= PROBE_I;
      prb_s2 <= prb_s1;
      ext_s1 <= EXT_CLK_I;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      evt_s1 <= XEVT_I;
      evt_s2 <= evt_s1;
   end

   assign ext_tick = ctrl_q[CTRL_EXTFALL] ? (ext_s3 & ~ext_s2)
                                          : (ext_s2 & ~ext_s3);
   assign int_tick = (divc_q == 16'h0000);
   assign tick = ctrl_q[CTRL_EXTCLK] ? ext_tick : int_tick;

   // internal sample clock: one-cycle enable every div_q+1 cycles
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I || start_p)
      begin
         divc_q <= 16'h0000;
      end
      else if (int_tick)
      begin
         divc_q <= div_q;
      end
      else
      begin
         divc_q <= divc_q - 16'h0001;
      end
   end

   // time stamp counts master clocks from start
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I || start_p)
      begin
         stamp_q <= ZERO_RST;
      end
      else if (running)
      begin
         stamp_q <= stamp_q + 32'h0000_0001;
      end
   end

   // sample only on tick while running
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I)
      begin
         smp_vld_q <= 1'b0;
         smp_q <= '0;
         smp_ts_q <= ZERO_RST;
      end
      else
      begin
         smp_vld_q <= running & tick;
         if (running && tick)
         begin
            smp_q <= prb_s2;
            smp_ts_q <= stamp_q;
         end
      end
   end

   assign hit = (ctrl_q[CTRL_EN_MATCH] && masked_eq(smp_q, match_q, mmask_q))
             || (ctrl_q[CTRL_EN_RANGE] && smp_q >= rlo_q && smp_q <= rhi_q)
             || (ctrl_q[CTRL_EN_EVENT] && evt_s2)
             || (ctrl_q[CTRL_EN_COUNT] && clim_q != ZERO_RST
                 && scnt_q + 32'h0000_0001 == clim_q);
   assign qual = masked_eq(smp_q, qval_q, qmask_q);
   assign trig_w = hit & ~trig_q;

   // same sample drives trigger and write path
   assign fif.in_valid = smp_vld_q & qual & running;
   assign fif.in_data = {trig_w, smp_ts_q, smp_q};

   // trigger state, sample counter and overflow flag
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I || start_p)
      begin
         trig_q <= 1'b0;
         scnt_q <= ZERO_RST;
         ovf_q <= 1'b0;
      end
      else if (smp_vld_q && running)
      begin
         scnt_q <= scnt_q + 32'h0000_0001;
         if (hit)
         begin
            trig_q <= 1'b1;
         end
         // full buffer means the memory side was held too long
         if (qual && !fif.in_ready)
         begin
            ovf_q <= 1'b1;
         end
      end
   end

   // hold bit lets software freeze the drain and inspect memory
   assign drain = ~ctrl_q[CTRL_HOLD];
   assign fif.out_ready = drain;
   assign pop_w = fif.out_data;
   // window full: DONE lags a cycle, so block any further write
   assign fin = mtrig_q && (post_q >= term);
   assign store_w = fif.out_valid & drain & running & ~fin;

   assign term = (pre_q >= DEPTH_C) ? (AW+1)'(1) : DEPTH_C - pre_q;

   // circular write, fill saturates at depth
   always_ff @(posedge MCLK_I)
   begin
      if (store_w)
      begin
         mem_smp_q[wptr_q] <= pop_w[PW-1:0];
         mem_ts_q[wptr_q] <= pop_w[PW+31:PW];
      end
   end

   // pointers and post-trigger count
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I || start_p)
      begin
         wptr_q <= '0;
         fill_q <= '0;
         post_q <= '0;
         mtrig_q <= 1'b0;
         tidx_q <= '0;
      end
      else if (store_w)
      begin
         wptr_q <= wptr_q + (AW)'(1);
         if (fill_q != DEPTH_C)
         begin
            fill_q <= fill_q + (AW+1)'(1);
         end
         // count written words from the trigger on
         if (pop_w[EW-1] && !mtrig_q)
         begin
            mtrig_q <= 1'b1;
            tidx_q <= wptr_q;
            post_q <= (AW+1)'(1);
         end
         else if (mtrig_q)
         begin
            post_q <= post_q + (AW+1)'(1);
         end
      end
   end

   // acquisition control: idle, running, done
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I)
      begin
         st_q <= ST_IDLE;
      end
      else if (abort_p)
      begin
         st_q <= ST_IDLE;
      end
      else if (start_p)
      begin
         st_q <= ST_RUN;
      end
      else
      begin
         unique case (st_q)
            ST_IDLE: st_q <= ST_IDLE;
            ST_RUN:
            begin
               // stop only after trigger and terminal count
               if (mtrig_q && post_q >= term)
               begin
                  st_q <= ST_DONE;
               end
            end
            ST_DONE: st_q <= ST_DONE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // trigger pulse for neighbouring modules
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I)
      begin
         TRIG_OUT_O <= 1'b0;
      end
      else
      begin
         TRIG_OUT_O <= smp_vld_q & running & trig_w;
      end
   end

   // software-written registers
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I)
      begin
         ctrl_q <= CTRL_RST;
         div_q <= DIV_RST;
         match_q <= '0;
         mmask_q <= '0;
         rlo_q <= '0;
         rhi_q <= '0;
         clim_q <= ZERO_RST;
         qval_q <= '0;
         qmask_q <= '0;
         pre_q <= '0;
         ridx_q <= '0;
      end
      else if (apb_wr)
      begin
         unique case (PADDR_I)
            // start and abort are pulses and are not stored
            OFS_CTRL: ctrl_q <= PWDATA_I[CTRL_BITS-1:0] & 9'h1FC;
            OFS_DIV: div_q <= PWDATA_I[15:0];
            OFS_MATCH: match_q <= PWDATA_I[PW-1:0];
            OFS_MMASK: mmask_q <= PWDATA_I[PW-1:0];
            OFS_RLO: rlo_q <= PWDATA_I[PW-1:0];
            OFS_RHI: rhi_q <= PWDATA_I[PW-1:0];
            OFS_CLIM: clim_q <= PWDATA_I;
            OFS_QVAL: qval_q <= PWDATA_I[PW-1:0];
            OFS_QMASK: qmask_q <= PWDATA_I[PW-1:0];
            OFS_PRE: pre_q <= PWDATA_I[AW:0];
            OFS_RIDX: ridx_q <= PWDATA_I[AW-1:0];
            default: ;
         endcase
      end
   end

   // read mux, zero wait state; unmapped reads answer zero and error
   always_comb
   begin
      PRDATA_O = ZERO_RST;
      PSLVERR_O = 1'b0;
      PREADY_O = 1'b1;
      unique case (PADDR_I)
         OFS_CTRL: PRDATA_O = 32'(ctrl_q);
         OFS_DIV: PRDATA_O = 32'(div_q);
         OFS_MATCH: PRDATA_O = 32'(match_q);
         OFS_MMASK: PRDATA_O = 32'(mmask_q);
         OFS_RLO: PRDATA_O = 32'(rlo_q);
         OFS_RHI: PRDATA_O = 32'(rhi_q);
         OFS_CLIM: PRDATA_O = clim_q;
         OFS_QVAL: PRDATA_O = 32'(qval_q);
         OFS_QMASK: PRDATA_O = 32'(qmask_q);
         OFS_PRE: PRDATA_O = 32'(pre_q);
         OFS_STAT: PRDATA_O = 32'({ovf_q, fill_q == DEPTH_C,
                                    st_q == ST_DONE, trig_q, running});
         OFS_FILL: PRDATA_O = 32'(fill_q);
         OFS_WPTR: PRDATA_O = 32'(wptr_q);
         OFS_RIDX: PRDATA_O = 32'(ridx_q);
         OFS_RDAT: PRDATA_O = 32'(mem_smp_q[ridx_q]);
         OFS_RSTMP: PRDATA_O = mem_ts_q[ridx_q];
         OFS_TIDX: PRDATA_O = 32'(tidx_q);
         default: PSLVERR_O = PSEL_I & PENABLE_I;
      endcase
      if (!apb_rd)
      begin
         PRDATA_O = ZERO_RST;
      end
   end

endmodule

// ---- tcs_pkg.sv ----
// Purpose: shared constants for the trace capture and trigger store
// Assumes: 32-bit APB register window, byte addresses
// Notes: all offsets and register field positions live here, with the control, divider and 32-bit zero reset values
package tcs_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIV = 8'h04;
   localparam logic [7:0] OFS_MATCH = 8'h08;
   localparam logic [7:0] OFS_MMASK = 8'h0C;
   localparam logic [7:0] OFS_RLO = 8'h10;
   localparam logic [7:0] OFS_RHI = 8'h14;
   localparam logic [7:0] OFS_CLIM = 8'h18;
   localparam logic [7:0] OFS_QVAL = 8'h1C;
   localparam logic [7:0] OFS_QMASK = 8'h20;
   localparam logic [7:0] OFS_PRE = 8'h24;
   localparam logic [7:0] OFS_STAT = 8'h28;
   localparam logic [7:0] OFS_FILL = 8'h2C;
   localparam logic [7:0] OFS_WPTR = 8'h30;
   localparam logic [7:0] OFS_RIDX = 8'h34;
   localparam logic [7:0] OFS_RDAT = 8'h38;
   localparam logic [7:0] OFS_RSTMP = 8'h3C;
   localparam logic [7:0] OFS_TIDX = 8'h40;

   // control register bit positions
   localparam int CTRL_START = 0;
   localparam int CTRL_ABORT = 1;
   localparam int CTRL_EXTCLK = 2;
   localparam int CTRL_EXTFALL = 3;
   localparam int CTRL_EN_MATCH = 4;
   localparam int CTRL_EN_RANGE = 5;
   localparam int CTRL_EN_EVENT = 6;
   localparam int CTRL_EN_COUNT = 7;
   localparam int CTRL_HOLD = 8;
   localparam int CTRL_BITS = 9;

   // status register bit positions
   localparam int STAT_RUN = 0;
   localparam int STAT_TRIG = 1;
   localparam int STAT_DONE = 2;
   localparam int STAT_FULL = 3;
   localparam int STAT_OVF = 4;

   // reset values
   localparam logic [CTRL_BITS-1:0] CTRL_RST = 9'h000;
   localparam logic [15:0] DIV_RST = 16'h0004;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;

   // acquisition states, one-hot
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } tcs_state_e;

endpackage

// ---- tcs_fifo_if.sv ----
// Purpose: valid/ready carrier between capture logic and its buffer
// Assumes: one clock, both sides on MCLK_I
// Notes: store modport is the buffer, user modport is the top module
`timescale 1ns/1ps
interface tcs_fifo_if #(parameter int W = 8);
   logic in_valid; // word offered by the capture side
   logic in_ready; // buffer has room
   logic [W-1:0] in_data;
   logic out_valid; // buffer holds a word
   logic out_ready; // memory side takes it
   logic [W-1:0] out_data;
   modport store
   (
      input in_valid, in_data, out_ready,
      output in_ready, out_valid, out_data
   );
   modport user
   (
      output in_valid, in_data, out_ready,
      input in_ready, out_valid, out_data
   );
endinterface

// ---- tcs_buf2.sv ----
// Purpose: two-entry valid/ready buffer in the sample path
// Assumes: synchronous active-high reset
// Notes: in_ready is registered-state based so it never loops to in_valid
`timescale 1ns/1ps
module tcs_buf2
   import tcs_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   tcs_fifo_if.store bus
);

   logic [W-1:0] mem_q [2]; // two storage slots
   logic rd_q; // slot read next
   logic wr_q; // slot written next
   logic [1:0] cnt_q; // words held

   logic push;
   logic pop;

   // honest full and empty straight from the count
   assign bus.in_ready = (cnt_q != 2'h2);
   assign bus.out_valid = (cnt_q != 2'h0);
   assign bus.out_data = mem_q[rd_q];
   assign push = bus.in_valid & bus.in_ready;
   assign pop = bus.out_valid & bus.out_ready;

   // storage write, no reset needed on data
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= bus.in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= ~wr_q;
         end
         if (pop)
         begin
            rd_q <= ~rd_q;
         end
         // simultaneous push and pop keep the count
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 2'h1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end

endmodule

// ---- tcs_capture_sva.sv ----
// Purpose: port-level checks for the capture and trigger store
// Assumes: zero wait state APB, one clock domain
// Notes: helper flags track start, abort and trigger pulses
`timescale 1ns/1ps
module tcs_capture_sva
   import tcs_pkg::*;
#(
   parameter int PW = 32,
   parameter int DEPTH = 256
)
(
   input wire logic MCLK_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [PW-1:0] PROBE_I,
   input wire logic EXT_CLK_I,
   input wire logic XEVT_I,
   input wire logic TRIG_OUT_O
);
   wire logic acc = PSEL_I && PENABLE_I; // access phase
   wire logic rd = PSEL_I && !PWRITE_I; // read data shown
   wire logic cw = acc && PWRITE_I && PADDR_I == OFS_CTRL; // control write
   logic run_q; // an acquisition was started
   logic seen_q; // trigger already fired in this run
   // abort wins so a stray pulse after abort is caught
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I || (cw && PWDATA_I[CTRL_ABORT]))
         run_q <= 1'b0;
      else if (cw && PWDATA_I[CTRL_START])
         run_q <= 1'b1;
   end
   // start rearms the trigger
   always_ff @(posedge MCLK_I)
   begin
      if (SRST_I || (cw && PWDATA_I[CTRL_START]))
         seen_q <= 1'b0;
      else if (TRIG_OUT_O)
         seen_q <= 1'b1;
   end
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SRST_I);
   a_ready_high: assert property (PREADY_O)
      else $error("pready low");
   a_idle_rdata_zero: assert property (!rd |-> PRDATA_O == 32'h0)
      else $error("read data without read");
   a_unmapped_err: assert property (acc && PADDR_I > OFS_TIDX |->
      PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0)) else $error("no error");
   a_mapped_ok: assert property (acc && PADDR_I <= OFS_TIDX &&
      PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O) else $error("error on map");
   a_trig_pulse_one: assert property (TRIG_OUT_O |=> !TRIG_OUT_O)
      else $error("trigger pulse long");
   a_trig_once: assert property (TRIG_OUT_O |-> !seen_q)
      else $error("second trigger");
   a_trig_running: assert property (TRIG_OUT_O |-> run_q)
      else $error("trigger while idle");
   a_fill_bound: assert property (rd && PADDR_I == OFS_FILL |->
      PRDATA_O <= DEPTH) else $error("fill above depth");
   a_done_after_trig: assert property (rd && PADDR_I == OFS_STAT &&
      PRDATA_O[STAT_DONE] |-> PRDATA_O[STAT_TRIG]) else $error("done early");
   c_trig: cover property (TRIG_OUT_O);
   c_err: cover property (acc && PSLVERR_O);
   c_done: cover property (rd && PADDR_I == OFS_STAT && PRDATA_O[STAT_DONE]);
endmodule
bind tcs_capture tcs_capture_sva #(.PW(PW), .DEPTH(DEPTH)) i_sva
(
   .MCLK_I(MCLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .PROBE_I(PROBE_I), .EXT_CLK_I(EXT_CLK_I),
   .XEVT_I(XEVT_I), .TRIG_OUT_O(TRIG_OUT_O)
);

// ---- tcs_target_model.sv ----
// Purpose: target system driving the probes and its own clock
// Assumes: target clock runs only while a frame is open
// Notes: probe counts up on each falling target clock edge
`timescale 1ns/1ps
module tcs_target_model
#(
   parameter int PW = 32
)
(
   input wire logic frame_i,
   input wire logic evt_i,
   output logic ext_clk_o,
   output logic [PW-1:0] probe_o,
   output logic xevt_o
);
   // clock stands low between frames; odd offset keeps phase unrelated
   initial
   begin
      ext_clk_o = 1'b0;
      probe_o = '0;
      forever
      begin
         @(posedge frame_i);
         probe_o = '0;
         #13;
         while (frame_i)
         begin
            #100 ext_clk_o = 1'b1;
            #100 ext_clk_o = 1'b0;
            probe_o = probe_o + 1'b1;
         end
      end
   end
   // event from a neighbour module, short path delay
   assign #7 xevt_o = evt_i;
endmodule

// ---- test_tcs_capture.sv ----
// Purpose: self-checking bench for the capture and trigger store
// Assumes: APB master here, target model on the probes
// Notes: expectations are fixed bench constants, the random value written to MATCH, or come from the wp_exp bench function
`timescale 1ns/1ps
module test_tcs_capture;
   import tcs_pkg::*;
   localparam int DEPTH = 256;
   logic clk, rst, psel, pen, pwr, frame, evt, er, rdy, err;
   logic ext_clk, xevt, trig;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, probe, rdv, sd, ss, t0, tidx, rnd;
   int n_checks, n_mismatch, cyc, seed, n_trig;
   tcs_capture i_dut
   (
      .MCLK_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(err),
      .PROBE_I(probe), .EXT_CLK_I(ext_clk), .XEVT_I(xevt),
      .TRIG_OUT_O(trig)
   );
   tcs_target_model #(.PW(32)) i_tgt
   (
      .frame_i(frame), .evt_i(evt), .ext_clk_o(ext_clk),
      .probe_o(probe), .xevt_o(xevt)
   );
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // expected slot after the last stored word
   function automatic logic [31:0] wp_exp(logic [31:0] t, int pre);
      return (t + ((pre >= DEPTH) ? 1 : DEPTH - pre)) % DEPTH;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard, far above the roughly one thousand cycles needed
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   // trigger pulses seen on the output pin, checked once per run
   always @(posedge clk)
   begin
      if (trig === 1'b1)
      begin
         n_trig <= n_trig + 1;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 50);
      rdv = prdata;
      er = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // word and stamp at a physical slot
   task automatic rd_at(input logic [31:0] i);
      wr(OFS_RIDX, i % DEPTH);
      rd(OFS_RDAT);
      sd = rdv;
      rd(OFS_RSTMP);
      ss = rdv;
   endtask
   task automatic run(input logic [31:0] c);
      int n;
      int k;
      k = n_trig;
      wr(OFS_CTRL, c | 32'h1);
      frame <= 1'b1;
      n = 0;
      do
      begin
         rd(OFS_STAT);
         n++;
      end
      while (rdv[STAT_DONE] !== 1'b1 && n < 3000);
      frame <= 1'b0;
      chk(rdv & 32'h6, 32'h6);
      chk(n_trig - k, 32'h1);
      rd(OFS_TIDX);
      tidx = rdv;
   endtask
   initial
   begin
      seed = 32'h3f9c;
      cyc = 0;
      {rst, psel, pen, pwr, frame, evt} = 6'h20;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // reset values, read-only and unmapped places
      rd(OFS_DIV);
      chk(rdv, 32'h4);
      rd(OFS_FILL);
      chk(rdv, 32'h0);
      rnd = $random(seed);
      wr(OFS_MATCH, rnd);
      rd(OFS_MATCH);
      chk(rdv, rnd);
      wr(OFS_STAT, 32'hFFFF);
      rd(OFS_STAT);
      chk(rdv, 32'h0);
      rd(8'h44);
      chk({rdv[30:0], er}, 32'h1);
      // start shows running, abort returns to idle without done
      wr(OFS_CTRL, 32'h1);
      rd(OFS_STAT);
      chk(rdv & 32'h1, 32'h1);
      wr(OFS_CTRL, 32'h2);
      rd(OFS_STAT);
      chk(rdv & 32'h5, 32'h0);
      $display("registers done");
      wr(OFS_DIV, $unsigned($random(seed)) % 4);
      wr(OFS_MATCH, 32'h5);
      wr(OFS_MMASK, 32'hFFFFFFFF);
      wr(OFS_PRE, DEPTH - 4);
      run(32'h10);
      rd(OFS_WPTR);
      chk(rdv, wp_exp(tidx, DEPTH - 4));
      rd_at(tidx);
      chk(sd, 32'h5);
      t0 = ss;
      rd_at(tidx - 1);
      chk(sd, 32'h4);
      chk({31'h0, t0 > ss}, 32'h1);
      $display("value trigger done");
      wr(OFS_QMASK, 32'h1);
      wr(OFS_RLO, 32'd20);
      wr(OFS_RHI, 32'd21);
      wr(OFS_PRE, DEPTH - 2);
      run(32'h24);
      rd(OFS_WPTR);
      chk(rdv, wp_exp(tidx, DEPTH - 2));
      rd_at(tidx);
      chk(sd, 32'd20);
      rd_at(tidx - 1);
      chk(sd, 32'd18);
      rd_at(tidx + 1);
      chk(sd, 32'd22);
      $display("range trigger done");
      wr(OFS_QMASK, 32'h0);
      wr(OFS_DIV, 32'h0);
      wr(OFS_PRE, DEPTH - 1);
      evt <= 1'b1;
      run(32'h40);
      evt <= 1'b0;
      rd(OFS_WPTR);
      chk(rdv, wp_exp(tidx, DEPTH - 1));
      $display("event trigger done");
      wr(OFS_CLIM, 32'd300);
      wr(OFS_PRE, 32'h0);
      run(32'h80);
      rd(OFS_FILL);
      chk(rdv, DEPTH);
      rd(OFS_STAT);
      chk(rdv & 32'h8, 32'h8);
      rd(OFS_WPTR);
      chk(rdv, wp_exp(tidx, 0));
      rd_at(tidx);
      t0 = ss;
      rd_at(tidx + 1);
      chk(ss - t0, 32'h1);
      $display("counter trigger done");
      complete_run();
   end
endmodule
